// [bench/spfs_flash_model.sv]
`timescale 1ns/1ps
// Flash macro stand-in: ends each page op a set number of cycles after start
module spfs_flash_model (
    input  wire logic       i_clk,   // Core clock
    input  wire logic       i_rst_n, // Async reset, active low
    input  wire logic       i_start, // Page op start pulse
    input  wire logic [7:0] i_lat,   // Cycles until done, 2 or more
    output logic            o_done   // Op finished pulse
);
    logic [7:0] cnt;

    // Count down from start and pulse done once at the end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 8'h01);
            if (i_start) begin
                cnt <= i_lat - 8'h01;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// [bench/tb_self_programming_flash_sections.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_self_programming_flash_sections
    import spfs_pkg::*;
;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, spm_v, ld_v, grant, deny;
    logic fstart, fwr, fdone, halt, busy, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] exec, ld_a, rvec, tg;
    logic [7:0]  fpage, lat;
    spfs_fuse_s  fuse;
    spfs_req_s   req;
    logic s_start, s_halt, s_busy, s_wr, s_grant, s_deny;
    logic [7:0] s_page;
    int n_fail = 0;
    int num_checks = 0;

    spfs_seq i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_fuse(fuse), .i_spm_valid(spm_v),
        .i_spm_req(req), .i_exec_addr(exec), .i_load_valid(ld_v), .i_load_addr(ld_a),
        .o_load_grant(grant), .o_load_deny(deny), .o_flash_start(fstart),
        .o_flash_write(fwr), .o_flash_page(fpage), .i_flash_done(fdone),
        .o_cpu_halt(halt), .o_rww_blocked(busy), .o_reset_vector(rvec), .o_irq(irq));
    spfs_flash_model i_flash (.i_clk(clk), .i_rst_n(rst_n), .i_start(fstart),
        .i_lat(lat), .o_done(fdone));

    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [13:0] bstart(input logic [1:0] s);
        case (s)
            2'h3: return BOOT_START3;
            2'h2: return BOOT_START2;
            2'h1: return BOOT_START1;
            default: return BOOT_START0;
        endcase
    endfunction

    // One APB transfer; waits for ready, takes data at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask

    // Store-program or load op pulse, outputs sampled one cycle later
    task automatic issue(input logic sp, input logic w, input logic [13:0] t,
                         input logic [13:0] ex);
        spm_v <= sp; ld_v <= !sp; req <= {w, t}; ld_a <= t; exec <= ex;
        @(posedge clk);
        spm_v <= 1'b0; ld_v <= 1'b0;
        @(posedge clk);
        {s_start, s_halt, s_busy, s_wr, s_page} = {fstart, halt, busy, fwr, fpage};
        {s_grant, s_deny} = {grant, deny};
    endtask

    // Wait for flash done, check halt drops, then clear busy
    task automatic finish;
        int t;
        t = 0;
        while (fdone !== 1'b1 && t < 300) begin
            @(posedge clk);
            t++;
        end
        `CHK("done", 1'b1, fdone)
        @(posedge clk);
        `CHK("halt_end", 1'b0, halt)
        apb(1'b1, OFS_CTRL, 32'h1);
    endtask

    task automatic reset_dut;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up;
    end

    initial begin
        {psel, pen, pwr, spm_v, ld_v} = 5'h0;
        {paddr, pwdata, exec, ld_a, req} = '0;
        fuse = 7'h7F;
        lat = 8'h08;
        rst_n = 1'b0;
        void'($urandom(38));
        @(posedge clk);
        // Reset vector and boot start per size code, boot page op halts core
        for (int s = 0; s < 4; s++) begin
            fuse <= {s[1:0], 1'b0, 4'hF};
            reset_dut;
            `CHK("rvec", bstart(s[1:0]), rvec)
            issue(1'b1, 1'b0, bstart(s[1:0]), bstart(s[1:0]));
            `CHK("no_concurrent_read_region_start", 1'b1, s_start)
            `CHK("no_concurrent_read_region_halt", 1'b1, s_halt)
            apb(1'b0, OFS_STATUS, 32'h0);
            `CHK("stat_halt", (32'h1 << ST_HALT) | (32'h1 << ST_PROG), rd)
            finish;
        end
        $display("test vectors done");
        fuse <= 7'h7F;
        reset_dut;
        `CHK("rvec_app", APP_RESET, rvec)
        apb(1'b0, OFS_IRQ_MSK, 32'h0);
        `CHK("mask_rst", 32'h0, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        $display("test regs done");
        // Ops from application code are refused
        issue(1'b1, 1'b1, 14'h0100, 14'($urandom % 14'h3F00));
        `CHK("app_start", 1'b0, s_start)
        apb(1'b0, OFS_IRQ_ST, 32'h0);
        `CHK("rej_flag", 32'h2, rd)
        apb(1'b1, OFS_IRQ_ST, 32'h2);
        apb(1'b1, OFS_IRQ_MSK, 32'h1);
        $display("test app refuse done");
        // Random read-while-write page ops from boot code
        for (int i = 0; i < 4; i++) begin
            tg = 14'($urandom % 14'h3800);
            lat <= 8'h28;
            issue(1'b1, i[0], tg, 14'h3F00 + 14'($urandom % 256));
            `CHK("rww_start", 1'b1, s_start)
            `CHK("rww_halt", 1'b0, s_halt)
            `CHK("rww_busy", 1'b1, s_busy)
            `CHK("page", tg[13:6], s_page)
            `CHK("kind", i[0], s_wr)
            issue(1'b0, 1'b0, tg, 14'h3F10);
            `CHK("rww_load", 1'b1, s_deny)
            issue(1'b0, 1'b0, 14'h3900, 14'h3F10);
            `CHK("no_concurrent_read_region_load", 1'b1, s_grant)
            apb(1'b1, OFS_CTRL, 32'h1);
            `CHK("early_clr", 1'b1, busy)
            apb(1'b0, OFS_STATUS, 32'h0);
            `CHK("stat_busy", (32'h1 << ST_BUSY) | (32'h1 << ST_PROG), rd)
            finish;
            @(posedge clk);
            `CHK("irq_done", 1'b1, irq)
            apb(1'b0, OFS_STATUS, 32'h0);
            `CHK("busy_clr", 1'b0, rd[ST_BUSY])
            apb(1'b1, OFS_IRQ_ST, 32'h3);
            @(posedge clk);
            `CHK("irq_clr", 1'b0, irq)
        end
        $display("test rww done");
        // Every protect code on both sections
        for (int c = 0; c < 4; c++) begin
            fuse <= {3'h6, c[1:0], c[1:0]};
            lat <= 8'(2 + $urandom % 8);
            reset_dut;
            issue(1'b1, 1'b1, 14'h0040, 14'h3F00);
            `CHK("app_prot_wr", c[0], s_start)
            if (s_start === 1'b1) finish;
            issue(1'b0, 1'b0, 14'h0040, 14'h3F00);
            `CHK("app_prot_ld", c[1], s_grant)
            issue(1'b1, 1'b1, 14'h3F80, 14'h3F00);
            `CHK("boot_prot_wr", c[0], s_start)
            if (s_start === 1'b1) finish;
            issue(1'b0, 1'b0, 14'h3F80, 14'h0100);
            `CHK("boot_prot_ld", c[1], s_grant)
        end
        $display("test protect done");
        wrap_up;
    end
endmodule

// [rtl/spfs_pkg.sv]
package spfs_pkg;
    // Flash geometry in program words
    localparam int          ADDR_W      = 14;
    localparam int          PAGE_LSB    = 6;
    localparam int          PAGE_W      = ADDR_W - PAGE_LSB;
    localparam logic [13:0] NO_CONCURRENT_READ_REGION_START  = 14'h3800;
    localparam logic [13:0] APP_RESET   = 14'h0000;
    // Boot section start per size fuse code, 11 smallest to 00 largest
    localparam logic [13:0] BOOT_START3 = 14'h3F00;
    localparam logic [13:0] BOOT_START2 = 14'h3E00;
    localparam logic [13:0] BOOT_START1 = 14'h3C00;
    localparam logic [13:0] BOOT_START0 = 14'h3800;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_IRQ_ST  = 12'h008;
    localparam logic [11:0] OFS_IRQ_MSK = 12'h00C;
    // Field positions
    localparam int          CTRL_CLR    = 0;
    localparam int          ST_BUSY     = 0;
    localparam int          ST_PROG     = 1;
    localparam int          ST_HALT     = 2;
    localparam int          IRQ_DONE    = 0;
    localparam int          IRQ_REJ     = 1;
    localparam int          IRQ_W       = 2;
    // Interrupt register reset value and last reset-vector capture count
    localparam logic [1:0]  IRQ_RST     = 2'h0;
    localparam logic [1:0]  CAP_LAST    = 2'h3;

    // Store-program request from the core
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] target;
    } spfs_req_s;

    // Fuse and lock bit levels, 1 means unprogrammed
    typedef struct packed {
        logic [1:0] boot_size;
        logic       boot_reset;
        logic [1:0] app_prot;
        logic [1:0] boot_prot;
    } spfs_fuse_s;
endpackage

// [rtl/spfs_seq.sv]
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module spfs_seq
    import spfs_pkg::*;
(
    input  wire logic              i_clk,          // Core clock
    input  wire logic              i_rst_n,        // Async reset, active low
    input  wire logic              i_psel,         // APB select
    input  wire logic              i_penable,      // APB enable
    input  wire logic              i_pwrite,       // APB write
    input  wire logic [11:0]       i_paddr,        // APB byte address
    input  wire logic [31:0]       i_pwdata,       // APB write data
    output logic      [31:0]       o_prdata,       // APB read data
    output logic                   o_pready,       // APB ready
    output logic                   o_pslverr,      // APB error, unmapped
    input  wire spfs_fuse_s        i_fuse,         // Fuse levels from pins
    input  wire logic              i_spm_valid,    // Store-program op pulse
    input  wire spfs_req_s         i_spm_req,      // Op kind and target
    input  wire logic [ADDR_W-1:0] i_exec_addr,    // Address of issuing code
    input  wire logic              i_load_valid,   // Load-program op pulse
    input  wire logic [ADDR_W-1:0] i_load_addr,    // Load target
    output logic                   o_load_grant,   // Load allowed
    output logic                   o_load_deny,    // Load refused
    output logic                   o_flash_start,  // Page op start pulse
    output logic                   o_flash_write,  // 1 write, 0 erase
    output logic      [PAGE_W-1:0] o_flash_page,   // Page number
    input  wire logic              i_flash_done,   // Flash op finished
    output logic                   o_cpu_halt,     // Core halt
    output logic                   o_rww_blocked,  // Busy flag
    output logic      [ADDR_W-1:0] o_reset_vector, // Reset vector
    output logic                   o_irq           // Interrupt, high level
);

    typedef enum logic {SPFS_IDLE, SPFS_PROG} spfs_state_e;

    spfs_state_e       state_reg;
    spfs_fuse_s        fuse_meta_reg;
    spfs_fuse_s        fuse_reg;
    spfs_req_s         req_reg;
    logic [1:0]        cap_cnt_reg;
    logic [IRQ_W-1:0]  irq_st_reg;
    logic [IRQ_W-1:0]  irq_msk_reg;
    logic [IRQ_W-1:0]  irq_st_next;
    logic [IRQ_W-1:0]  irq_ev;
    logic [ADDR_W-1:0] boot_start;
    logic              exec_boot;
    logic              tgt_boot;
    logic              wr_block;
    logic              spm_ok;
    logic              spm_rej;
    logic              wr_en;
    logic              clr_req;
    logic              ld_block;

    // Start of boot section for a size fuse code
    function automatic logic [ADDR_W-1:0] boot_base(input logic [1:0] sz);
        unique case (sz)
            2'h3: boot_base = BOOT_START3;
            2'h2: boot_base = BOOT_START2;
            2'h1: boot_base = BOOT_START1;
            2'h0: boot_base = BOOT_START0;
        endcase
    endfunction

    // Region test, shared by programming and loads
    function automatic logic in_no_concurrent_read_region(input logic [ADDR_W-1:0] a);
        in_no_concurrent_read_region = (a >= NO_CONCURRENT_READ_REGION_START);
    endfunction

    // Fuse pins pass two flops before use
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fuse_meta_reg <= '1;
            fuse_reg      <= '1;
        end else begin
            fuse_meta_reg <= i_fuse;
            fuse_reg      <= fuse_meta_reg;
        end
    end

    // Section and protection decode
    always_comb begin
        boot_start = boot_base(fuse_reg.boot_size);
        exec_boot  = (i_exec_addr >= boot_start);
        tgt_boot   = (i_spm_req.target >= boot_start);
        // Programmed bit 0 of a section's code forbids writes
        wr_block   = tgt_boot ? !fuse_reg.boot_prot[0]
                              : !fuse_reg.app_prot[0];
        spm_ok     = i_spm_valid && (state_reg == SPFS_IDLE) && exec_boot
                     && !wr_block;
        spm_rej    = i_spm_valid && !spm_ok;
    end

    // Load check: cross-section reads per bit 1, blocked region while busy
    always_comb begin
        ld_block = 1'b0;
        if (exec_boot && (i_load_addr < boot_start) && !fuse_reg.app_prot[1]) begin
            ld_block = 1'b1;
        end
        if (!exec_boot && (i_load_addr >= boot_start) && !fuse_reg.boot_prot[1]) begin
            ld_block = 1'b1;
        end
        if (o_rww_blocked && !in_no_concurrent_read_region(i_load_addr)) begin
            ld_block = 1'b1;
        end
    end

    // Load answer, one cycle after the request; pages play no part
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_load_grant <= 1'b0;
            o_load_deny  <= 1'b0;
        end else begin
            o_load_grant <= i_load_valid && !ld_block;
            o_load_deny  <= i_load_valid && ld_block;
        end
    end

    // Programming sequencer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg     <= SPFS_IDLE;
            req_reg       <= '0;
            o_flash_start <= 1'b0;
            o_flash_write <= 1'b0;
            o_flash_page  <= '0;
            o_cpu_halt    <= 1'b0;
        end else begin
            o_flash_start <= spm_ok;
            unique case (state_reg)
                SPFS_IDLE: begin
                    if (spm_ok) begin
                        state_reg     <= SPFS_PROG;
                        req_reg       <= i_spm_req;
                        o_flash_write <= i_spm_req.write;
                        o_flash_page  <= i_spm_req.target[ADDR_W-1:PAGE_LSB];
                        o_cpu_halt    <= in_no_concurrent_read_region(i_spm_req.target);
                    end
                end
                SPFS_PROG: begin
                    if (i_flash_done) begin
                        state_reg  <= SPFS_IDLE;
                        o_cpu_halt <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Busy flag: set by a read-while-write start, set wins over clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rww_blocked <= 1'b0;
        end else if (spm_ok && !in_no_concurrent_read_region(i_spm_req.target)) begin
            o_rww_blocked <= 1'b1;
        end else if (clr_req && (state_reg == SPFS_IDLE)) begin
            o_rww_blocked <= 1'b0;
        end
    end

    // Reset vector caught a few cycles after release, once fuses settle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_cnt_reg    <= '0;
            o_reset_vector <= APP_RESET;
        end else if (cap_cnt_reg != CAP_LAST) begin
            cap_cnt_reg    <= cap_cnt_reg + 2'h1;
            o_reset_vector <= fuse_reg.boot_reset ? APP_RESET : boot_start;
        end
    end

    // Bus decode; access completes in the cycle after setup
    assign wr_en   = i_psel && i_penable && o_pready && i_pwrite;
    assign clr_req = wr_en && (i_paddr == OFS_CTRL) && i_pwdata[CTRL_CLR];

    // Ready, read data and error prepared in the setup cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
            if (i_psel && !i_penable) begin
                unique case (i_paddr)
                    OFS_CTRL:    o_prdata <= '0;
                    OFS_STATUS:  o_prdata <= {29'h0, o_cpu_halt,
                                              state_reg == SPFS_PROG, o_rww_blocked};
                    OFS_IRQ_ST:  o_prdata <= {30'h0, irq_st_reg};
                    OFS_IRQ_MSK: o_prdata <= {30'h0, irq_msk_reg};
                    default:     o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Interrupt events: op finished, op refused
    always_comb begin
        irq_ev           = '0;
        irq_ev[IRQ_DONE] = (state_reg == SPFS_PROG) && i_flash_done;
        irq_ev[IRQ_REJ]  = spm_rej;
        irq_st_next      = irq_st_reg;
        if (wr_en && (i_paddr == OFS_IRQ_ST)) begin
            irq_st_next = irq_st_reg & ~i_pwdata[IRQ_W-1:0];
        end
        irq_st_next = irq_st_next | irq_ev;
    end

    // Sticky status, mask and level output
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_st_reg  <= IRQ_RST;
            irq_msk_reg <= IRQ_RST;
            o_irq       <= 1'b0;
        end else begin
            irq_st_reg <= irq_st_next;
            if (wr_en && (i_paddr == OFS_IRQ_MSK)) begin
                irq_msk_reg <= i_pwdata[IRQ_W-1:0];
            end
            o_irq <= |(irq_st_reg & irq_msk_reg);
        end
    end

    // Checks
    property p_app_drop;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_spm_valid && !exec_boot |=> !o_flash_start;
    endproperty
    a_app_drop: assert property (p_app_drop) else $error("op from application started");

    property p_boot_only;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_flash_start |-> $past(exec_boot) && $past(i_spm_valid);
    endproperty
    a_boot_only: assert property (p_boot_only) else $error("start without boot op");

    property p_any_target;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_spm_valid && exec_boot && state_reg == SPFS_IDLE && fuse_reg.boot_prot == 2'h3
        && fuse_reg.app_prot == 2'h3 |=> o_flash_start;
    endproperty
    a_any_target: assert property (p_any_target) else $error("open op not started");

    property p_app_prot;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_spm_valid && !tgt_boot && !fuse_reg.app_prot[0] |=> !o_flash_start;
    endproperty
    a_app_prot: assert property (p_app_prot) else $error("protected app written");

    property p_boot_prot;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_spm_valid && tgt_boot && !fuse_reg.boot_prot[0] |=> !o_flash_start;
    endproperty
    a_boot_prot: assert property (p_boot_prot) else $error("protected boot written");

    property p_rww_run;
        @(posedge i_clk) disable iff (!i_rst_n)
        spm_ok && !in_no_concurrent_read_region(i_spm_req.target) |=> !o_cpu_halt && o_rww_blocked;
    endproperty
    a_rww_run: assert property (p_rww_run) else $error("halt on rww op");

    property p_no_concurrent_read_region_halt;
        @(posedge i_clk) disable iff (!i_rst_n)
        spm_ok && in_no_concurrent_read_region(i_spm_req.target) |=> o_cpu_halt [*1] ##0
        (o_cpu_halt throughout (state_reg == SPFS_PROG));
    endproperty
    a_no_concurrent_read_region_halt: assert property (p_no_concurrent_read_region_halt) else $error("no halt on no_concurrent_read_region op");

    property p_boot_in_no_concurrent_read_region;
        @(posedge i_clk) disable iff (!i_rst_n)
        in_no_concurrent_read_region(boot_start);
    endproperty
    a_boot_in_no_concurrent_read_region: assert property (p_boot_in_no_concurrent_read_region) else $error("boot outside no_concurrent_read_region");

    property p_busy_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_rww_blocked && !clr_req |=> o_rww_blocked;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped alone");

    property p_page;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_flash_start |-> o_flash_page == $past(i_spm_req.target[ADDR_W-1:PAGE_LSB]);
    endproperty
    a_page: assert property (p_page) else $error("wrong page");

    property p_clr_ignored;
        @(posedge i_clk) disable iff (!i_rst_n)
        state_reg == SPFS_PROG && o_rww_blocked |=> o_rww_blocked;
    endproperty
    a_clr_ignored: assert property (p_clr_ignored) else $error("busy cleared early");

    property p_vector;
        @(posedge i_clk) disable iff (!i_rst_n)
        cap_cnt_reg == CAP_LAST |-> o_reset_vector ==
        (fuse_reg.boot_reset ? APP_RESET : boot_start);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong reset vector");

    property p_halt_span;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_cpu_halt && !i_flash_done |=> o_cpu_halt;
    endproperty
    a_halt_span: assert property (p_halt_span) else $error("halt dropped mid op");

    property p_ld_busy;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_load_valid && o_rww_blocked && !in_no_concurrent_read_region(i_load_addr) |=> o_load_deny;
    endproperty
    a_ld_busy: assert property (p_ld_busy) else $error("blocked region load granted");

    property p_ld_cross;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_load_valid && exec_boot && (i_load_addr < boot_start) && !fuse_reg.app_prot[1]
        |=> o_load_deny;
    endproperty
    a_ld_cross: assert property (p_ld_cross) else $error("cross load granted");

    property p_reject;
        @(posedge i_clk) disable iff (!i_rst_n)
        spm_rej |=> irq_st_reg[IRQ_REJ];
    endproperty
    a_reject: assert property (p_reject) else $error("refused op not flagged");

endmodule
